// ==== hw/bp_consts.svh ====
// constants for the card backplane: instruction bus codes, widths, timing
// assumes inclusion by bare name from package and design modules
//
// What this block does
// [R1] data values travel on 28-bit binary bus
// [R2] 4-bit bus carries decimal point position
// [R3] 4-bit bus carries error flags
// [R4] binary_data_valid qualifies data, point, flags
// [R5] 8-bit instruction bus with valid, complete lines
// [R6] instruction is 4-bit address plus command
// [R7] each card owns a unique address
// [R8] fixed addresses for interface, compensation, multiplier
// [R9] command code meaning fixed system-wide
// [R10] cards watch bus, act only on theirs
// [R11] instruction itself implies talker and listener
// [R12] counter drives data and valid on 2
// [R13] host card captures data, requests service on error
// [R14] multiplier scales data by corrected wavelength
// [R15] four dedicated lines with fixed meanings
// [R16] system reset returns all cards to start
// [R17] sample command latches displacement on all axes
// [R18] counters drive quarter or eighth-wave mode
// [R19] comparator drives destination-reached status
// [R20] host asserts instruction_valid, refuses new meanwhile
// [R21] busy listener stalls transfer until conversion done
// [R22] instruction held until operation_complete given
`ifndef BP_CONSTS_SVH
`define BP_CONSTS_SVH

`define BP_DATA_W 28
`define BP_DP_W 4
`define BP_ERR_W 4
`define BP_INS_W 8
// address field is the upper nibble, command the lower
`define BP_ADDR_HI 7
`define BP_ADDR_LO 4
`define BP_CMD_HI 3
`define BP_CMD_LO 0
// card addresses on the 4-bit address field
`define BP_ADDR_HOSTIF 4'h0
`define BP_ADDR_COMP 4'hE
`define BP_ADDR_MULT 4'hD
`define BP_ADDR_X 4'h1
`define BP_ADDR_Y 4'h2
`define BP_ADDR_Z 4'h3
`define BP_ADDR_A 4'h4
`define BP_ADDR_B 4'h5
`define BP_ADDR_C 4'h6
// command codes
`define BP_CMD_OUTPUT 4'h2
`define BP_CMD_CONVERT 4'h3
// conversion time of host card in cycles
`define BP_CONV_CYC 9
// system reset pulse length in cycles
`define BP_RST_CYC 4

`endif

// ==== hw/bp_pkg.sv ====
// types shared by both backplane ends
// assumes bp_consts.svh on the include path
`include "bp_consts.svh"
package bp_pkg;
  typedef logic [`BP_DATA_W-1:0] data_t;
  typedef logic [`BP_DP_W-1:0] dp_t;
  typedef logic [`BP_ERR_W-1:0] err_t;
  typedef logic [`BP_INS_W-1:0] ins_t;
endpackage

// ==== hw/bp_if.sv ====
// backplane carrier joining a host interface card and an axis counter card
// assumes one system clock shared by both cards
`timescale 1ns/1ps
`include "bp_consts.svh"
interface bp_if;
  logic [`BP_DATA_W-1:0] data;
  logic [`BP_DP_W-1:0] dp;
  logic [`BP_ERR_W-1:0] err;
  logic binary_data_valid;
  logic [`BP_INS_W-1:0] ins;
  logic instruction_valid;
  logic operation_complete;
  logic sys_reset;
  logic sync_sample;
  logic lambda_mode;
  logic sys_null;
  logic stall;
  modport host (
    input data, dp, err, binary_data_valid, operation_complete,
    input lambda_mode, sys_null,
    output ins, instruction_valid, sys_reset, sync_sample, stall
  );
  modport axis (
    output data, dp, err, binary_data_valid, operation_complete,
    output lambda_mode, sys_null,
    input ins, instruction_valid, sys_reset, sync_sample, stall
  );
endinterface

// ==== hw/bp_axis_card.sv ====
// axis counter/comparator card end of the backplane
// assumes host end drives the instruction and broadcast lines
`timescale 1ns/1ps
`include "bp_consts.svh"
module bp_axis_card #(
  parameter logic [3:0] MY_ADDR = `BP_ADDR_X // [R7]
) (
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  bp_if.axis bp,
  input wire logic [`BP_DATA_W-1:0] i_position,
  input wire logic [`BP_DP_W-1:0] i_dp,
  input wire logic [`BP_ERR_W-1:0] i_err,
  input wire logic i_eighth_wave,
  input wire logic [`BP_DATA_W-1:0] i_target,
  output logic o_reset_seen
);
  typedef struct packed {
    bp_pkg::data_t samp;
    bp_pkg::dp_t dp;
    bp_pkg::err_t err;
    logic talk;
    logic done;
    bp_pkg::data_t bus_data;
    bp_pkg::dp_t bus_dp;
    bp_pkg::err_t bus_err;
    logic lmode;
    logic null_hit;
    logic rst_seen;
  } st_s;
  st_s st_reg;
  st_s st_next;
  logic [3:0] addr;
  logic [3:0] cmd;
  assign addr = bp.ins[`BP_ADDR_HI:`BP_ADDR_LO]; // [R6]
  assign cmd = bp.ins[`BP_CMD_HI:`BP_CMD_LO];
  // ===========================================
  // next state
  always_comb
  begin
    st_next = st_reg;
    st_next.lmode = i_eighth_wave; // [R18]
    st_next.null_hit = (st_reg.samp == i_target); // [R19]
    st_next.rst_seen = 1'b0;
    if (bp.sync_sample)
    begin
      st_next.samp = i_position; // [R17]
      st_next.dp = i_dp;
      st_next.err = i_err;
    end
    // only own address and output command act here [R10] [R11] [R9]
    if (bp.instruction_valid && addr == MY_ADDR &&
        cmd == `BP_CMD_OUTPUT)
    begin
      st_next.talk = 1'b1; // [R12]
      st_next.done = st_reg.talk && !bp.stall; // [R21] [R22]
    end
    else
    begin
      st_next.talk = 1'b0;
      st_next.done = 1'b0;
    end
    if (bp.sys_reset)
    begin
      st_next = '0; // [R16]
      st_next.rst_seen = 1'b1;
    end
    // bus drivers are registered copies, zero while not talking
    st_next.bus_data = st_next.talk ? st_next.samp : '0; // [R1]
    st_next.bus_dp = st_next.talk ? st_next.dp : '0; // [R2]
    st_next.bus_err = st_next.talk ? st_next.err : '0; // [R3]
  end
  // ===========================================
  // state register
  always_ff @(posedge i_clk_sys or negedge i_rstn)
  begin
    if (!i_rstn)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end
  // drive the bus only while selected, straight from flops [R4]
  assign bp.data = st_reg.bus_data;
  assign bp.dp = st_reg.bus_dp;
  assign bp.err = st_reg.bus_err;
  assign bp.binary_data_valid = st_reg.talk;
  assign bp.operation_complete = st_reg.done; // [R5]
  assign bp.lambda_mode = st_reg.lmode; // [R15]
  assign bp.sys_null = st_reg.null_hit;
  assign o_reset_seen = st_reg.rst_seen;
endmodule

// ==== hw/bp_host_card.sv ====
// host interface card end: issues instructions, captures axis output
// assumes user side offers one instruction at a time with a valid strobe
`timescale 1ns/1ps
`include "bp_consts.svh"
module bp_host_card #(
  parameter int CONV_CYC = `BP_CONV_CYC,
  parameter logic [27:0] WAVELEN = 28'h0000001
) (
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  bp_if.host bp,
  input wire logic [3:0] i_cmd,
  input wire logic [3:0] i_addr,
  input wire logic i_ins_valid,
  output logic o_ins_ready,
  input wire logic i_sys_reset,
  input wire logic i_sync_sample,
  output logic [`BP_DATA_W-1:0] o_data,
  output logic [`BP_DP_W-1:0] o_dp,
  output logic [`BP_ERR_W-1:0] o_err,
  output logic [55:0] o_product,
  output logic o_srq,
  output logic o_busy
);
  typedef enum logic [2:0] {
    S_IDLE = 3'b001,
    S_ISSUE = 3'b010,
    S_RESET = 3'b100
  } hst_e;
  typedef struct packed {
    hst_e state;
    bp_pkg::ins_t ins;
    logic ins_on;
    logic rst;
    logic [2:0] rcnt;
    logic samp;
    logic [3:0] conv;
    bp_pkg::data_t data;
    bp_pkg::dp_t dp;
    bp_pkg::err_t err;
    logic [55:0] prod;
    logic srq;
    logic rdy;
    logic stall;
  } st_s;
  st_s st_reg;
  st_s st_next;
  // ===========================================
  // next state
  always_comb
  begin
    st_next = st_reg;
    st_next.samp = i_sync_sample; // [R17]
    if (st_reg.conv != 4'h0)
      st_next.conv = st_reg.conv - 4'h1;
    // capture whatever axis talks [R13] [R11]
    if (st_reg.ins_on && bp.binary_data_valid &&
        st_reg.ins[`BP_CMD_HI:`BP_CMD_LO] == `BP_CMD_OUTPUT)
    begin
      st_next.data = bp.data; // [R1]
      st_next.dp = bp.dp; // [R2]
      st_next.err = bp.err; // [R3]
      st_next.prod = 56'(bp.data) * 56'(WAVELEN); // [R14]
      if (bp.err != '0)
        st_next.srq = 1'b1;
    end
    case (st_reg.state)
      S_IDLE:
      begin
        if (i_sys_reset)
        begin
          st_next.state = S_RESET;
          st_next.rst = 1'b1;
          st_next.rcnt = 3'h0;
          st_next.rdy = 1'b0;
        end
        else if (i_ins_valid && st_reg.rdy) // [R20]
        begin
          st_next.ins = {i_addr, i_cmd}; // [R6]
          st_next.ins_on = 1'b1; // [R5]
          st_next.rdy = 1'b0;
          st_next.state = S_ISSUE;
          if (i_cmd == `BP_CMD_CONVERT && i_addr == `BP_ADDR_HOSTIF) // [R8]
            st_next.conv = 4'(CONV_CYC);
        end
      end
      S_ISSUE:
      begin
        // hold until complete, or convert done for own command [R22]
        if (bp.operation_complete ||
            (st_reg.ins[`BP_ADDR_HI:`BP_ADDR_LO] == `BP_ADDR_HOSTIF &&
             st_reg.conv == 4'h0))
        begin
          st_next.ins_on = 1'b0;
          st_next.rdy = 1'b1;
          st_next.state = S_IDLE;
        end
      end
      S_RESET:
      begin
        st_next.rcnt = st_reg.rcnt + 3'h1;
        if (st_reg.rcnt == 3'(`BP_RST_CYC - 1)) // [R16]
        begin
          st_next = '0;
          st_next.state = S_IDLE;
          st_next.rdy = 1'b1;
        end
      end
      default:
        st_next.state = S_IDLE;
    endcase
    // stall is a flop so the backplane sees no decode glitch
    st_next.stall = (st_next.conv != 4'h0); // [R21]
  end
  // ===========================================
  // state register; reset leaves the system reset pulse running [R16]
  always_ff @(posedge i_clk_sys or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      st_reg <= '0;
      st_reg.state <= S_RESET;
      st_reg.rst <= 1'b1;
    end
    else
      st_reg <= st_next;
  end
  // every backplane and user output comes straight from a flop
  assign bp.ins = st_reg.ins;
  assign bp.instruction_valid = st_reg.ins_on;
  assign bp.sys_reset = st_reg.rst; // [R15]
  assign bp.sync_sample = st_reg.samp;
  assign bp.stall = st_reg.stall; // [R21]
  assign o_ins_ready = st_reg.rdy;
  assign o_data = st_reg.data;
  assign o_dp = st_reg.dp;
  assign o_err = st_reg.err;
  assign o_product = st_reg.prod;
  assign o_srq = st_reg.srq;
  assign o_busy = st_reg.ins_on;
endmodule

// ==== dv/bp_properties.sv ====
// checker for the backplane wires between host and axis card
// assumes axis card at address 1 and the interface signals fed in
`timescale 1ns/1ps
module bp_properties (
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  input wire logic [7:0] ins,
  input wire logic instruction_valid,
  input wire logic operation_complete,
  input wire logic binary_data_valid,
  input wire logic sys_reset,
  input wire logic stall
);
  // ==========================================
  // protocol properties
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rstn);
  property p_talk;
    $rose(instruction_valid) && ins == 8'h12 |=> binary_data_valid;
  endproperty
  a_talk: assert property (p_talk) else $error("no talk");
  property p_qual;
    $rose(binary_data_valid) |-> instruction_valid && ins == 8'h12;
  endproperty
  a_qual: assert property (p_qual) else $error("bad talk");
  property p_deaf;
    instruction_valid && ins[7:4] != 4'h1 |-> !binary_data_valid;
  endproperty
  a_deaf: assert property (p_deaf) else $error("wrong card");
  property p_done;
    $rose(binary_data_valid) && !stall |=> operation_complete;
  endproperty
  a_done: assert property (p_done) else $error("no done");
  property p_hold;
    instruction_valid && !operation_complete |=> $stable(ins);
  endproperty
  a_hold: assert property (p_hold) else $error("ins moved");
  property p_drop;
    operation_complete |=> !instruction_valid;
  endproperty
  a_drop: assert property (p_drop) else $error("valid held");
  property p_rst;
    $rose(sys_reset) |-> sys_reset[*4] ##1 !sys_reset;
  endproperty
  a_rst: assert property (p_rst) else $error("reset len");
  property p_stall;
    $rose(stall) |-> (instruction_valid throughout stall[*8]);
  endproperty
  a_stall: assert property (p_stall) else $error("short stall");
endmodule

// ==== dv/tb_top.sv ====
// self-checking bench: host card and axis card face each other
// assumes design files and checker compiled before this one
`timescale 1ns/1ps
module tb_top;
  logic i_clk_sys, i_rstn, i_eighth_wave, i_ins_valid;
  logic i_sys_reset, i_sync_sample, o_ins_ready, o_srq;
  logic o_busy, o_reset_seen, seen, busy_seen;
  logic [27:0] i_position, i_target, o_data;
  logic [3:0] i_dp, i_err, i_cmd, i_addr, o_dp, o_err;
  logic [55:0] o_product;
  logic [35:0] cap;
  logic [7:0] cap_ins;
  int n_fail, check_count, cyc, lat;
  bp_if bp ();
  bp_host_card u_bp_host_card (.i_clk_sys, .i_rstn, .bp(bp), .i_cmd,
    .i_addr, .i_ins_valid, .o_ins_ready, .i_sys_reset, .i_sync_sample,
    .o_data, .o_dp, .o_err, .o_product, .o_srq, .o_busy);
  bp_axis_card #(.MY_ADDR(4'h1)) u_bp_axis_card (.i_clk_sys, .i_rstn,
    .bp(bp), .i_position, .i_dp, .i_err, .i_eighth_wave, .i_target,
    .o_reset_seen);
  bp_properties u_bp_properties (.i_clk_sys, .i_rstn, .ins(bp.ins),
    .instruction_valid(bp.instruction_valid), .stall(bp.stall),
    .operation_complete(bp.operation_complete),
    .binary_data_valid(bp.binary_data_valid), .sys_reset(bp.sys_reset));
  // ==========================================
  // clock and hang guard
  initial
  begin
    i_clk_sys = 1'b0;
    forever #10 i_clk_sys = ~i_clk_sys;
  end
  always @(posedge i_clk_sys)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_fail++;
      test_done;
    end
  end
  // ==========================================
  // shared tasks
  task chk(input logic [55:0] s, input logic [55:0] e);
    check_count++;
    if (s !== e)
    begin
      n_fail++;
      $display("ERROR %0t seen %h want %h", $time, s, e);
    end
  endtask
  task samp(input logic [27:0] p, input logic [3:0] d, input logic [3:0] e);
    @(posedge i_clk_sys);
    i_position <= p;
    i_dp <= d;
    i_err <= e;
    i_sync_sample <= 1'b1;
    repeat (2) @(posedge i_clk_sys);
    i_sync_sample <= 1'b0;
    repeat (3) @(posedge i_clk_sys);
    i_position <= ~p; // moves on after the sample
  endtask
  task issue(input logic [3:0] a, input logic [3:0] c);
    @(negedge i_clk_sys);
    while (o_ins_ready !== 1'b1) @(negedge i_clk_sys);
    @(posedge i_clk_sys);
    i_addr <= a;
    i_cmd <= c;
    i_ins_valid <= 1'b1;
    @(posedge i_clk_sys);
    i_ins_valid <= 1'b0;
    lat = 0;
    busy_seen = 1'b0;
    do
    begin
      @(negedge i_clk_sys);
      lat++;
      if (bp.binary_data_valid === 1'b1) cap = {bp.err, bp.dp, bp.data};
      if (bp.instruction_valid === 1'b1) cap_ins = bp.ins;
      if (o_busy === 1'b1) busy_seen = 1'b1;
    end
    while (o_ins_ready !== 1'b1);
  endtask
  task test_done;
    $display("checks %0d errors %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // ==========================================
  // scenarios
  task t_output;
    samp(28'h0ABCDEF, 4'h3, 4'h0);
    issue(4'h1, 4'h2);
    chk(cap_ins, 8'h12);
    chk(cap, 36'h030ABCDEF);
    chk({o_err, o_dp, o_data}, 36'h030ABCDEF);
    chk(o_product, 56'h0ABCDEF);
    chk(o_srq, 1'b0);
  endtask
  task t_error;
    samp(28'h0FFFFFF, 4'h0, 4'h5);
    issue(4'h1, 4'h2);
    chk(cap[35:32], 4'h5);
    chk(o_srq, 1'b1);
    samp(28'h0000001, 4'h1, 4'h0);
    issue(4'h1, 4'h2);
    chk(o_srq, 1'b1);
  endtask
  task t_sysreset;
    @(posedge i_clk_sys);
    i_sys_reset <= 1'b1;
    @(posedge i_clk_sys);
    i_sys_reset <= 1'b0;
    seen = 1'b0;
    repeat (12) @(negedge i_clk_sys) if (o_reset_seen === 1'b1) seen = 1'b1;
    chk(seen, 1'b1);
    chk(o_srq, 1'b0);
  endtask
  task t_convert;
    issue(4'h0, 4'h3);
    chk(lat >= 9, 1'b1);
    chk(busy_seen, 1'b1);
    chk(o_busy, 1'b0);
  endtask
  task t_status;
    @(posedge i_clk_sys);
    i_eighth_wave <= 1'b1;
    i_target <= 28'h0000400;
    samp(28'h0000400, 4'h0, 4'h0);
    @(negedge i_clk_sys);
    chk({bp.lambda_mode, bp.sys_null}, 2'h3);
    @(posedge i_clk_sys);
    i_eighth_wave <= 1'b0;
    i_target <= 28'h0000401;
    repeat (3) @(posedge i_clk_sys);
    @(negedge i_clk_sys);
    chk({bp.lambda_mode, bp.sys_null}, 2'h0);
  endtask
  // ==========================================
  // main sequence
  initial
  begin
    {i_rstn, i_eighth_wave, i_ins_valid, i_sys_reset, i_sync_sample} = 5'h0;
    {i_position, i_target, i_dp, i_err, i_cmd, i_addr} = 72'h0;
    repeat (5) @(posedge i_clk_sys);
    i_rstn <= 1'b1;
    // the power-up system reset would wipe an early sample
    do @(negedge i_clk_sys); while (o_ins_ready !== 1'b1);
    t_output;
    t_error;
    t_sysreset;
    t_convert;
    t_status;
    test_done;
  end
endmodule
